/* File: rtl/dchrx_regs.vh */
// constants for the d-channel hdlc receiver
`ifndef DCHRX_REGS_VH
`define DCHRX_REGS_VH
// ----------------------------------------
// buffer depths and thresholds
// ----------------------------------------
`define DCHRX_DEPTH_NORM 6'h08
`define DCHRX_DEPTH_EXT 6'h20
`define DCHRX_EXT_BIT 0
`define DCHRX_THR_N0 6'h01
`define DCHRX_THR_N1 6'h02
`define DCHRX_THR_N2 6'h04
`define DCHRX_THR_N3 6'h08
`define DCHRX_THR_E0 6'h04
`define DCHRX_THR_E1 6'h08
`define DCHRX_THR_E2 6'h10
`define DCHRX_THR_E3 6'h20
// ----------------------------------------
// line coding and check sequence
// ----------------------------------------
`define DCHRX_STUFF_ONES 4'h5
`define DCHRX_FLAG_ONES 4'h6
`define DCHRX_MARK_IDLE 4'hf
`define DCHRX_PIPE_BITS 3'h7
`define DCHRX_FCS_PRESET 16'hffff
`define DCHRX_FCS_POLY 16'h1021
`define DCHRX_FCS_GOOD 16'h1d0f
`define DCHRX_MIN_LEN 16'h0005
// ----------------------------------------
// mode register bit positions
// ----------------------------------------
`define DCHRX_M1_THRESH 1
`define DCHRX_M1_EOP 3
`define DCHRX_M3_ADDR 0
`define DCHRX_M3_LAST 2
`define DCHRX_M3_AVAIL 3
`define DCHRX_M3_FCS 7
// ----------------------------------------
// error and status bit positions
// ----------------------------------------
`define DCHRX_E_ABORT 0
`define DCHRX_E_NONINT 1
`define DCHRX_E_FCS 3
`define DCHRX_E_OVF 4
`define DCHRX_E_UNF 5
`define DCHRX_E_OVR 6
`define DCHRX_S1_ADDR 0
`define DCHRX_S1_EOP 1
`define DCHRX_S1_PROG 2
`define DCHRX_S2_LOST 2
`define DCHRX_S2_MARK 5
`define DCHRX_S2_FLAG 6
`endif

/* File: rtl/dchrx_fcs_check.v */
// serial frame check sequence checker
`include "dchrx_regs.vh"
module dchrx_fcs_check (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // serial data
  input wire fcs_init,
  input wire fcs_bit_en,
  input wire fcs_bit,
  // result
  output wire fcs_ok
);
  reg [15:0] crc;
  wire fb = crc[15] ^ fcs_bit;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      crc <= `DCHRX_FCS_PRESET;
    end else if (fcs_init) begin
      crc <= `DCHRX_FCS_PRESET;
    end else if (fcs_bit_en) begin
      crc <= {crc[14:0], 1'b0} ^ (fb ? `DCHRX_FCS_POLY : 16'h0000);
    end
  end

  assign fcs_ok = (crc == `DCHRX_FCS_GOOD);
endmodule // dchrx_fcs_check

/* File: rtl/dchrx_receiver.v */
// d-channel hdlc receive framer with packet buffer and status queues
`include "dchrx_regs.vh"
module dchrx_receiver (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // serial stream from line interface
  input wire rx_bit,
  input wire rx_bit_en,
  // configuration
  input wire [7:0] fifo_depth_ctrl,
  input wire [7:0] mode_reg_one,
  input wire [7:0] error_mask_reg,
  input wire [7:0] mode_reg_three,
  input wire [7:0] mode_reg_four,
  input wire [15:0] rx_limit_reg,
  input wire [31:0] first_byte_match,
  input wire [31:0] second_byte_match,
  input wire rx_abort,
  // software access strobes
  input wire rx_buffer_rd,
  input wire count_hi_rd,
  input wire status_one_rd,
  input wire status_two_rd,
  // readable state
  output reg [7:0] rx_buffer_port,
  output wire [15:0] rx_count_fifo,
  output wire [7:0] addr_status_fifo,
  output reg [7:0] error_fifo,
  output wire [7:0] status_reg_one,
  output wire [7:0] status_reg_two,
  output reg [5:0] rx_level,
  // events
  output reg addr_event,
  output reg byte_avail_event,
  output reg thresh_event,
  output reg eop_event,
  output reg last_read_event,
  output reg error_event
);
  localparam HUNT = 3'd0;
  localparam OPEN = 3'd1;
  localparam RECV = 3'd2;
  localparam DISC = 3'd3;
  localparam FLUSH = 3'd4;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [3:0] addr_hits;
    input [7:0] b1;
    input [7:0] b2;
    input [3:0] en;
    input [31:0] m1;
    input [31:0] m2;
    integer i;
    begin
      addr_hits = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        addr_hits[i] = en[i] & (b1 == m1[8*i +: 8]) & (b2 == m2[8*i +: 8]);
      end
    end
  endfunction

  function [7:0] pipe_sel;
    input [1:0] idx;
    input [7:0] q0;
    input [7:0] q1;
    input [7:0] q2;
    begin
      pipe_sel = (idx == 2'd0) ? q0 : ((idx == 2'd1) ? q1 : q2);
    end
  endfunction

  // ----------------------------------------
  // bit level: destuffing, flags, aborts
  // ----------------------------------------
  reg [3:0] ones;
  reg [6:0] dly;
  reg [2:0] dn;
  reg [7:0] sr;
  reg [2:0] bc;
  reg [2:0] st;
  wire fcs_ok;

  wire flag_det = rx_bit_en & ~rx_bit & (ones == `DCHRX_FLAG_ONES);
  wire abort_det = rx_bit_en & rx_bit & (ones == `DCHRX_FLAG_ONES);
  wire data_bit = rx_bit_en & (rx_bit ? (ones < `DCHRX_FLAG_ONES)
                                      : (ones < `DCHRX_STUFF_ONES));
  wire in_frame = (st == OPEN) | (st == RECV) | (st == DISC);
  // seven bits are held back so a flag's own bits never reach a byte
  wire adv = data_bit & in_frame & (dn == `DCHRX_PIPE_BITS);
  wire byte_done = adv & (bc == 3'd7);
  wire [7:0] new_byte = {dly[6], sr[7:1]};

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ones <= 4'h0;
    end else if (rx_bit_en) begin
      if (!rx_bit) begin
        ones <= 4'h0;
      end else if (ones != `DCHRX_MARK_IDLE) begin
        ones <= ones + 4'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dly <= 7'h00;
      dn <= 3'd0;
      sr <= 8'h00;
      bc <= 3'd0;
    end else if (flag_det | abort_det) begin
      dn <= 3'd0;
      bc <= 3'd0;
    end else if (data_bit & in_frame) begin
      dly <= {dly[5:0], rx_bit};
      if (dn != `DCHRX_PIPE_BITS) begin
        dn <= dn + 3'd1;
      end else begin
        sr <= new_byte;
        bc <= bc + 3'd1;
      end
    end
  end

  dchrx_fcs_check u_fcs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fcs_init(flag_det),
    .fcs_bit_en(adv),
    .fcs_bit(dly[6]),
    .fcs_ok(fcs_ok)
  );

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  reg [8:0] mem [0:31];
  reg [4:0] wp;
  reg [4:0] rp;
  reg [1:0] pkt_cnt;
  wire ext = fifo_depth_ctrl[`DCHRX_EXT_BIT];
  wire [5:0] depth = ext ? `DCHRX_DEPTH_EXT : `DCHRX_DEPTH_NORM;
  wire full = (rx_level == depth);
  wire [1:0] tsel = mode_reg_four[3:2];
  wire [5:0] thr = ext ? ((tsel == 2'd0) ? `DCHRX_THR_E0 :
                          (tsel == 2'd1) ? `DCHRX_THR_E1 :
                          (tsel == 2'd2) ? `DCHRX_THR_E2 : `DCHRX_THR_E3)
                       : ((tsel == 2'd0) ? `DCHRX_THR_N0 :
                          (tsel == 2'd1) ? `DCHRX_THR_N1 :
                          (tsel == 2'd2) ? `DCHRX_THR_N2 : `DCHRX_THR_N3);
  reg [7:0] p0;
  reg [7:0] p1;
  reg [7:0] p2;
  reg [1:0] pn;
  reg [1:0] fl_i;
  reg [1:0] fl_n;
  reg [4:0] wp_last;
  wire ovf_now;
  wire ab_now;
  // a byte that ends the packet goes out with the flush, never twice
  wire push_req = ((st == RECV) & byte_done & (pn == 2'd3) &
                   ~ovf_now & ~ab_now) |
                  ((st == FLUSH) & (fl_n != 2'd0));
  wire [7:0] push_data = (st == FLUSH) ? pipe_sel(fl_i, p0, p1, p2) : p2;
  wire push_last = (st == FLUSH) & (fl_n == 2'd1);
  wire push_en = push_req & ~full;
  wire pop_en = rx_buffer_rd & (rx_level != 6'd0);
  wire pop_last = pop_en & mem[rp][8];
  // overrun drops the tail byte, so the mark moves to the last byte kept
  wire tail_mark = (st == FLUSH) & (fl_n == 2'd1) & full;
  wire rec_now;
  wire [4:0] wp_nx = (wp + 5'd1 == depth[4:0]) | (wp == 5'd31) ? 5'd0
                     : wp + 5'd1;
  wire [4:0] rp_nx = (rp + 5'd1 == depth[4:0]) | (rp == 5'd31) ? 5'd0
                     : rp + 5'd1;
  wire [5:0] lvl_nx = rx_level + {5'd0, push_en} - {5'd0, pop_en};

  always @(posedge sys_clk) begin
    if (push_en) begin
      mem[wp] <= {push_last, push_data};
    end else if (tail_mark) begin
      mem[wp_last][8] <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wp <= 5'd0;
      wp_last <= 5'd0;
      rp <= 5'd0;
      rx_level <= 6'd0;
      rx_buffer_port <= 8'h00;
      pkt_cnt <= 2'd0;
    end else begin
      if (push_en) begin
        wp <= wp_nx;
        wp_last <= wp;
      end
      if (pop_en) begin
        rp <= rp_nx;
        rx_buffer_port <= mem[rp][7:0];
      end
      rx_level <= lvl_nx;
      // packets stay counted until their last byte is read
      pkt_cnt <= pkt_cnt + {1'b0, rec_now} - {1'b0, pop_last};
    end
  end

  // ----------------------------------------
  // packet state machine
  // ----------------------------------------
  reg [15:0] rc;
  reg [15:0] tc;
  reg [7:0] a1;
  reg [7:0] astat;
  reg [7:0] err;
  reg ret_open;
  reg in_prog;
  reg lost;
  reg [1:0] fcnt;
  wire [3:0] hits = addr_hits(a1, new_byte, mode_reg_one[7:4],
                              first_byte_match, second_byte_match);
  wire recog = |mode_reg_one[7:4];
  wire store_fcs = mode_reg_three[`DCHRX_M3_FCS];
  wire [15:0] rc_nx = rc + 16'd1;
  assign ovf_now = byte_done & (rc_nx > rx_limit_reg);
  wire ovr_now = push_req & full & (st == RECV);
  assign ab_now = abort_det | rx_abort;
  reg two_byte;
  wire unf_now = two_byte & (rc < `DCHRX_MIN_LEN) & (rc >= 16'd2);
  wire [1:0] keep_ok = store_fcs ? pn : ((pn == 2'd3) ? 2'd1 : 2'd0);
  reg addr_hit;
  assign rec_now = (st == FLUSH) & (fl_n == 2'd0) & (tc != 16'd0);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= HUNT;
      rc <= 16'd0;
      tc <= 16'd0;
      a1 <= 8'h00;
      astat <= 8'h00;
      err <= 8'h00;
      p0 <= 8'h00;
      p1 <= 8'h00;
      p2 <= 8'h00;
      pn <= 2'd0;
      fl_i <= 2'd0;
      fl_n <= 2'd0;
      ret_open <= 1'b0;
      in_prog <= 1'b0;
      lost <= 1'b0;
      addr_hit <= 1'b0;
      two_byte <= 1'b0;
    end else begin
      addr_hit <= 1'b0;
      if (status_two_rd) begin
        lost <= 1'b0;
      end
      if (push_en & (st == FLUSH)) begin
        fl_i <= fl_i - 2'd1;
      end
      if (push_en) begin
        tc <= tc + 16'd1;
      end
      case (st)
        HUNT: begin
          if (flag_det) begin
            st <= OPEN;
          end
        end
        OPEN: begin
          if (ab_now) begin
            st <= HUNT;
          end else if (byte_done) begin
            if (pkt_cnt == 2'd2) begin
              lost <= 1'b1;
              st <= DISC;
            end else begin
              in_prog <= 1'b1;
              a1 <= new_byte;
              p0 <= new_byte;
              pn <= 2'd1;
              rc <= 16'd1;
              tc <= 16'd0;
              err <= 8'h00;
              astat <= 8'h00;
              st <= RECV;
            end
          end
        end
        RECV: begin
          if (flag_det | ab_now | ovf_now | ovr_now) begin
            in_prog <= 1'b0;
            err[`DCHRX_E_ABORT] <= ab_now;
            err[`DCHRX_E_NONINT] <= flag_det & (bc != 3'd0);
            err[`DCHRX_E_FCS] <= flag_det & ~fcs_ok;
            err[`DCHRX_E_OVF] <= ovf_now & ~ab_now;
            err[`DCHRX_E_UNF] <= flag_det & unf_now;
            err[`DCHRX_E_OVR] <= ovr_now & ~ab_now;
            // on a good close the two newest bytes are the check sequence
            fl_n <= (flag_det & ~ab_now) ? keep_ok : pn;
            fl_i <= pn - 2'd1;
            ret_open <= flag_det;
            st <= FLUSH;
          end else if (byte_done) begin
            rc <= rc_nx;
            p0 <= new_byte;
            p1 <= p0;
            p2 <= p1;
            if (pn != 2'd3) begin
              pn <= pn + 2'd1;
            end
            if (rc == 16'd1) begin
              two_byte <= ~a1[0] & new_byte[0];
              if (recog & (hits == 4'h0)) begin
                in_prog <= 1'b0;
                pn <= 2'd0;
                st <= DISC;
              end else begin
                addr_hit <= 1'b1;
                astat <= {4'h0, hits};
              end
            end
          end
        end
        DISC: begin
          if (flag_det) begin
            st <= OPEN;
          end else if (ab_now) begin
            st <= HUNT;
          end
        end
        FLUSH: begin
          if (fl_n != 2'd0) begin
            fl_n <= fl_n - 2'd1;
          end else begin
            pn <= 2'd0;
            st <= ret_open ? OPEN : HUNT;
          end
        end
        default: begin
          st <= HUNT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // count, address status and error queues
  // ----------------------------------------
  reg [15:0] cq0;
  reg [15:0] cq1;
  reg [7:0] aq0;
  reg [7:0] aq1;
  reg [1:0] cn;
  reg [7:0] eq0;
  reg [7:0] eq1;
  reg [1:0] en_q;
  wire c_pop = count_hi_rd & (cn != 2'd0);
  wire e_pop = pop_last & (en_q != 2'd0);
  assign rx_count_fifo = cq0;
  assign addr_status_fifo = aq0;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cq0 <= 16'd0;
      cq1 <= 16'd0;
      aq0 <= 8'h00;
      aq1 <= 8'h00;
      cn <= 2'd0;
      eq0 <= 8'h00;
      eq1 <= 8'h00;
      en_q <= 2'd0;
      error_fifo <= 8'h00;
    end else begin
      // count high read moves the next entry forward
      if (c_pop) begin
        cq0 <= cq1;
        aq0 <= aq1;
      end
      if (rec_now & ((cn == 2'd0) | ((cn == 2'd1) & c_pop))) begin
        cq0 <= tc;
        aq0 <= astat;
      end else if (rec_now & (cn != 2'd2)) begin
        cq1 <= tc;
        aq1 <= astat;
      end
      cn <= cn + {1'b0, rec_now & (cn != 2'd2)} - {1'b0, c_pop};
      if (e_pop) begin
        error_fifo <= eq0;
        eq0 <= eq1;
      end
      if (rec_now & ((en_q == 2'd0) | ((en_q == 2'd1) & e_pop))) begin
        eq0 <= err;
      end else if (rec_now & (en_q != 2'd2)) begin
        eq1 <= err;
      end
      en_q <= en_q + {1'b0, rec_now & (en_q != 2'd2)} - {1'b0, e_pop};
    end
  end

  // ----------------------------------------
  // status and events
  // ----------------------------------------
  reg s1_addr;
  reg s1_eop;
  // a queued record reaching the head raises its status bits again
  wire head_adv = c_pop & (cn == 2'd2);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      fcnt <= 2'd0;
    end else if (abort_det | adv) begin
      fcnt <= 2'd0;
    end else if (flag_det & (st != RECV) & (fcnt != 2'd3)) begin
      fcnt <= fcnt + 2'd1;
    end
  end

  // a new event wins over a status read in the same cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_addr <= 1'b0;
      s1_eop <= 1'b0;
      addr_event <= 1'b0;
      byte_avail_event <= 1'b0;
      thresh_event <= 1'b0;
      eop_event <= 1'b0;
      last_read_event <= 1'b0;
      error_event <= 1'b0;
    end else begin
      s1_addr <= addr_hit | head_adv | (s1_addr & ~status_one_rd);
      s1_eop <= rec_now | head_adv | (s1_eop & ~status_one_rd);
      addr_event <= addr_hit & mode_reg_three[`DCHRX_M3_ADDR];
      byte_avail_event <= push_en & mode_reg_three[`DCHRX_M3_AVAIL];
      thresh_event <= push_en & (lvl_nx == thr) &
                      mode_reg_one[`DCHRX_M1_THRESH];
      eop_event <= rec_now & mode_reg_one[`DCHRX_M1_EOP];
      last_read_event <= pop_last & mode_reg_three[`DCHRX_M3_LAST];
      error_event <= e_pop & |(eq0 & error_mask_reg);
    end
  end

  assign status_reg_one = {5'h00, in_prog, s1_eop, s1_addr};
  assign status_reg_two = {1'b0, (fcnt == 2'd3),
                           (ones == `DCHRX_MARK_IDLE), 2'b00, lost,
                           2'b00};
endmodule // dchrx_receiver

/* File: tb/dchrx_receiver_sva.sv */
// assertions on the ports of the d-channel hdlc receiver
`include "dchrx_regs.vh"
module dchrx_receiver_sva (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // line and configuration
  input wire rx_bit,
  input wire rx_bit_en,
  input wire [7:0] fifo_depth_ctrl,
  input wire [7:0] mode_reg_one,
  input wire [7:0] error_mask_reg,
  input wire [7:0] mode_reg_three,
  input wire rx_buffer_rd,
  // readable state
  input wire [7:0] error_fifo,
  input wire [7:0] status_reg_one,
  input wire [7:0] status_reg_two,
  input wire [5:0] rx_level,
  // events
  input wire addr_event,
  input wire byte_avail_event,
  input wire thresh_event,
  input wire eop_event,
  input wire last_read_event,
  input wire error_event
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // event masks and status
  // ----------------------------------------
  property p_eop;
    eop_event |-> mode_reg_one[`DCHRX_M1_EOP] && status_reg_one[`DCHRX_S1_EOP];
  endproperty
  a_eop: assert property (p_eop) else $error("eop bad");
  property p_addr;
    addr_event |-> mode_reg_three[`DCHRX_M3_ADDR]
      ##[0:1] status_reg_one[`DCHRX_S1_ADDR];
  endproperty
  a_addr: assert property (p_addr) else $error("addr bad");
  property p_avail;
    byte_avail_event |-> mode_reg_three[`DCHRX_M3_AVAIL] && rx_level != 6'h00;
  endproperty
  a_avail: assert property (p_avail) else $error("avail bad");
  property p_thr;
    thresh_event |-> mode_reg_one[`DCHRX_M1_THRESH] && rx_level != 6'h00;
  endproperty
  a_thr: assert property (p_thr) else $error("thresh bad");
  property p_last;
    last_read_event |-> mode_reg_three[`DCHRX_M3_LAST] && $past(rx_buffer_rd);
  endproperty
  a_last: assert property (p_last) else $error("last bad");
  property p_err;
    last_read_event |-> error_event == |(error_fifo & error_mask_reg);
  endproperty
  a_err: assert property (p_err) else $error("err missing");
  property p_err_cause;
    error_event |-> $past(rx_buffer_rd) && (error_fifo & error_mask_reg) != 0;
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("err bad");
  // ----------------------------------------
  // buffer depth and idle detection
  // ----------------------------------------
  property p_level;
    rx_level <= (fifo_depth_ctrl[`DCHRX_EXT_BIT] ? `DCHRX_DEPTH_EXT
      : `DCHRX_DEPTH_NORM);
  endproperty
  a_level: assert property (p_level) else $error("level bad");
  // slack covers a detector placed behind the bit hold-back
  property p_mark;
    rx_bit_en && !rx_bit |-> ##[1:80] !status_reg_two[`DCHRX_S2_MARK];
  endproperty
  a_mark: assert property (p_mark) else $error("mark bad");
  c_eop: cover property (eop_event);
  c_err: cover property (last_read_event && error_event);
  c_lost: cover property (status_reg_two[`DCHRX_S2_LOST]);
  c_thr: cover property (thresh_event);
endmodule // dchrx_receiver_sva
bind dchrx_receiver dchrx_receiver_sva u_dchrx_receiver_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
  .fifo_depth_ctrl(fifo_depth_ctrl), .mode_reg_one(mode_reg_one),
  .error_mask_reg(error_mask_reg), .mode_reg_three(mode_reg_three),
  .rx_buffer_rd(rx_buffer_rd), .error_fifo(error_fifo),
  .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
  .rx_level(rx_level), .addr_event(addr_event),
  .byte_avail_event(byte_avail_event), .thresh_event(thresh_event),
  .eop_event(eop_event), .last_read_event(last_read_event),
  .error_event(error_event));

/* File: tb/dchrx_line_model.sv */
// line interface model feeding the serial d-channel stream
module dchrx_line_model (
  // clock
  input wire sys_clk,
  // serial stream
  output logic rx_bit,
  output logic rx_bit_en
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_bit = 1'b0;
    rx_bit_en = 1'b0;
  end
  // one bit every eight cycles, above the minimum strobe spacing
  task automatic put(input logic b);
    repeat (7) @(posedge sys_clk);
    #1;
    rx_bit = b;
    rx_bit_en = 1'b1;
    @(posedge sys_clk);
    #1;
    rx_bit_en = 1'b0;
    // unqualified between strobes, so never show the last bit
    rx_bit = ~b;
  endtask
  task automatic flag(input int n);
    repeat (n) for (int i = 0; i < 8; i++) put(i != 0 && i != 7);
  endtask
  task automatic ones(input int n);
    repeat (n) put(1'b1);
  endtask
  task automatic body(input logic q[$]);
    int run;
    run = 0;
    foreach (q[i]) begin
      put(q[i]);
      run = q[i] ? run + 1 : 0;
      // zero insertion keeps frame content apart from flags
      if (run == 5) begin
        put(1'b0);
        run = 0;
      end
    end
  endtask
endmodule // dchrx_line_model

/* File: tb/dchrx_receiver_test.sv */
// self-checking bench for the d-channel hdlc receiver
`include "dchrx_regs.vh"
module dchrx_receiver_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    int n; bit fcs; bit bad; int xb; logic [3:0] pr; logic ext;
    logic [15:0] lim; logic [7:0] err; logic [7:0] msk;
  } dchrx_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  wire rx_bit, rx_bit_en;
  logic [7:0] fifo_depth_ctrl = 8'h00;
  logic [7:0] mode_reg_one = 8'h0a;
  logic [7:0] error_mask_reg = 8'h7b;
  logic [7:0] mode_reg_three = 8'h0d;
  logic [7:0] mode_reg_four = 8'h00;
  logic [15:0] rx_limit_reg = 16'h0100;
  logic [31:0] first_byte_match = 32'h0402_0404;
  logic [31:0] second_byte_match = 32'h0503_0505;
  logic rx_abort = 1'b0, rx_buffer_rd = 1'b0, count_hi_rd = 1'b0;
  logic status_one_rd = 1'b0, status_two_rd = 1'b0;
  wire [7:0] rx_buffer_port, addr_status_fifo, error_fifo;
  wire [7:0] status_reg_one, status_reg_two;
  wire [15:0] rx_count_fifo;
  wire [5:0] rx_level;
  wire addr_event, byte_avail_event, thresh_event, eop_event;
  wire last_read_event, error_event;
  int n_fail = 0, checks = 0;
  int thr_seen = 0, thr_base = 0;
  logic fb[$];
  logic [7:0] exp_q[$];
  dchrx_row_t rows [7] = '{
    '{4, 0, 0, 0, 4'h0, 0, 16'h0100, 8'h00, 8'hff},
    '{3, 1, 0, 0, 4'h4, 0, 16'h0100, 8'h00, 8'hff},
    '{2, 0, 0, 0, 4'h0, 0, 16'h0100, 8'h20, 8'h20},
    '{5, 0, 1, 0, 4'h0, 0, 16'h0100, 8'h08, 8'h08},
    '{5, 0, 0, 3, 4'h0, 0, 16'h0100, 8'h02, 8'h02},
    '{6, 0, 0, 0, 4'h0, 0, 16'h0003, 8'h10, 8'h10},
    '{12, 0, 0, 0, 4'h0, 1, 16'h0100, 8'h00, 8'hff}};
  dchrx_line_model u_dchrx_line_model (.sys_clk(sys_clk), .rx_bit(rx_bit),
    .rx_bit_en(rx_bit_en));
  dchrx_receiver u_dchrx_receiver (.sys_clk(sys_clk), .rst_n(rst_n),
    .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .fifo_depth_ctrl(fifo_depth_ctrl),
    .mode_reg_one(mode_reg_one), .error_mask_reg(error_mask_reg),
    .mode_reg_three(mode_reg_three), .mode_reg_four(mode_reg_four),
    .rx_limit_reg(rx_limit_reg), .first_byte_match(first_byte_match),
    .second_byte_match(second_byte_match), .rx_abort(rx_abort),
    .rx_buffer_rd(rx_buffer_rd), .count_hi_rd(count_hi_rd),
    .status_one_rd(status_one_rd), .status_two_rd(status_two_rd),
    .rx_buffer_port(rx_buffer_port), .rx_count_fifo(rx_count_fifo),
    .addr_status_fifo(addr_status_fifo), .error_fifo(error_fifo),
    .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
    .rx_level(rx_level), .addr_event(addr_event),
    .byte_avail_event(byte_avail_event), .thresh_event(thresh_event),
    .eop_event(eop_event), .last_read_event(last_read_event),
    .error_event(error_event));
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (thresh_event) thr_seen <= thr_seen + 1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge sys_clk);
    #1 s = 1'b1;
    @(posedge sys_clk);
    #1 s = 1'b0;
  endtask
  // frame bits with a serial crc; check bits go out high bit first
  task automatic mk(input int n, input bit bad, input int xb);
    logic [15:0] crc;
    logic [7:0] d;
    fb = {};
    exp_q = {};
    crc = `DCHRX_FCS_PRESET;
    for (int i = 0; i < n; i++) begin
      d = i == 0 ? 8'h02 : i == 1 ? 8'h03 : i == 2 ? 8'hff : 8'h11 * i[7:0];
      for (int k = 0; k < 8; k++) fb.push_back(d[k]);
    end
    repeat (xb) fb.push_back(1'b0);
    foreach (fb[i])
      crc = {crc[14:0], 1'b0} ^ (crc[15] ^ fb[i] ? `DCHRX_FCS_POLY : 16'h0000);
    if (bad) crc[0] = ~crc[0];
    for (int k = 15; k >= 0; k--) fb.push_back(~crc[k]);
    for (int i = 0; i + 8 <= fb.size(); i += 8) begin
      for (int k = 0; k < 8; k++) d[k] = fb[i + k];
      exp_q.push_back(d);
    end
  endtask
  task automatic send(input int n, input bit bad, input int xb);
    mk(n, bad, xb);
    u_dchrx_line_model.flag(1);
    u_dchrx_line_model.body(fb);
    u_dchrx_line_model.flag(1);
    u_dchrx_line_model.ones(16);
  endtask
  // status, count and data of the head packet; cnt 0 skips data
  task automatic serve(input int cnt, input logic [7:0] ast,
    input logic [7:0] msk, input logic [7:0] err);
    int i;
    i = 0;
    chk(status_reg_one[`DCHRX_S1_EOP], 1'b1);
    if (cnt > 0) chk(status_reg_one[`DCHRX_S1_ADDR], 1'b1);
    if (cnt > 0) chk(rx_count_fifo, cnt[15:0]);
    chk(addr_status_fifo, ast);
    do begin
      pulse(rx_buffer_rd);
      if (cnt > 0) chk(rx_buffer_port, exp_q[i]);
      i++;
    end while (last_read_event !== 1'b1 && i < 40);
    if (cnt > 0) chk(i[15:0], cnt[15:0]);
    chk(error_fifo & msk, err);
    pulse(status_one_rd);
    pulse(count_hi_rd);
    if (last_read_event !== 1'b1 && i >= 40) begin
      n_fail++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk(status_reg_one, 8'h00);
    chk(status_reg_two, 8'h00);
    chk(rx_count_fifo, 16'h0000);
    chk(rx_level, 6'h00);
    foreach (rows[j]) begin
      fifo_depth_ctrl = {7'h00, rows[j].ext};
      mode_reg_one = {rows[j].pr, 4'ha};
      mode_reg_three = rows[j].fcs ? 8'h8d : 8'h0d;
      rx_limit_reg = rows[j].lim;
      error_mask_reg = rows[j].msk;
      // select one: eight bytes when extended, else the first table entry
      mode_reg_four = rows[j].ext ? 8'h04 : 8'h00;
      thr_base = thr_seen;
      send(rows[j].n, rows[j].bad, rows[j].xb);
      chk(16'(thr_seen - thr_base), 16'h0001);
      serve(rows[j].msk == 8'hff ? rows[j].n + 2 * rows[j].fcs : 0,
        {4'h0, rows[j].pr}, rows[j].msk, rows[j].err);
    end
    fifo_depth_ctrl = 8'h00;
    send(3, 0, 0);
    send(4, 0, 0);
    send(3, 0, 0);
    chk(status_reg_two[`DCHRX_S2_LOST], 1'b1);
    chk(status_reg_two[`DCHRX_S2_MARK], 1'b1);
    serve(3, 8'h00, 8'hff, 8'h00);
    mk(4, 0, 0);
    serve(4, 8'h00, 8'hff, 8'h00);
    chk(rx_level, 6'h00);
    pulse(status_two_rd);
    chk(status_reg_two[`DCHRX_S2_LOST], 1'b0);
    send(12, 0, 0);
    chk(rx_level, `DCHRX_DEPTH_NORM);
    serve(0, 8'h00, 8'h40, 8'h40);
    for (int s = 0; s < 2; s++) begin
      mk(6, 0, 0);
      u_dchrx_line_model.flag(1);
      u_dchrx_line_model.body(fb[0:39]);
      chk(status_reg_one[`DCHRX_S1_PROG], 1'b1);
      if (s == 0) u_dchrx_line_model.ones(8);
      else pulse(rx_abort);
      u_dchrx_line_model.ones(16);
      serve(0, 8'h00, {7'h00, s == 0}, {7'h00, s == 0});
    end
    mode_reg_one = 8'h8a;
    send(4, 0, 0);
    chk(status_reg_one[`DCHRX_S1_EOP], 1'b0);
    chk(rx_level, 6'h00);
    u_dchrx_line_model.flag(4);
    chk(status_reg_two[`DCHRX_S2_FLAG], 1'b1);
    u_dchrx_line_model.ones(16);
    chk(status_reg_two[`DCHRX_S2_FLAG], 1'b0);
    give_verdict();
  end
endmodule // dchrx_receiver_test
